/* File: hw/tcc_setup_ctrl.sv */
// setup word register and scan sequencer
// Contract
// - sixteen-bit word, fields from pen mode down
// - reads 4000h after reset, writes default 0000h
// - pen bit reads current touch state
// - pen mode 1 lets device scan functions 0/1
// - busy bit reads 0 busy, 1 idle
// - writing busy bit 1 aborts, powers down
// - stop request clears itself
// - resolution bit 0 10-bit, 1 12-bit
// - conversion control byte also sets resolution
// - rate select divides oscillator 1, 2, 4
// - settle delay before sampling from table
// - precharge interval before sensing from table
// - sense wait after conversion from table
// - wait-detect drives pin high on no touch, only while idle in pen mode 0
// - long sample adds two oscillator cycles
// - registers sixteen bits, four-bit address access
`timescale 1ns/1ps
module tcc_setup_ctrl
  import tcc_pkg::*;
(
  // clock and reset
  input  wire logic          CLOCK,
  input  wire logic          RST_N,
  // register port
  input  wire tcc_reg_req_t  REG_REQ,
  output logic [15:0]        REG_RDATA,
  output logic               REG_RVALID,
  // conversion control byte
  input  wire tcc_ctl1_t     CTL1,
  // panel and converter
  input  wire logic          PEN_TOUCH,
  input  wire logic          CONV_DONE,
  output logic               ADC_POWER,
  output logic               ADC_SAMPLE,
  output logic               ADC_START,
  output logic               ADC_RES12,
  output logic               ADC_CLK_EN,
  output logic               PANEL_DRIVE,
  output logic               PANEL_PRECHARGE,
  output logic               SCAN_ABORTED,
  output logic               TOUCH_OR_DATA_READY_PIN
);
  import tcc_pkg::*;

  tcc_setup_t       setup;
  tcc_state_t       state;
  tcc_state_t       next_state;
  logic [3:0]       func;
  logic             pen_m;
  logic             pen;
  logic             stop_req;
  logic [DLY_W-1:0] cnt;
  logic [DLY_W-1:0] next_cnt;
  logic             osc_tick;
  logic             adc_tick;
  logic             busy;
  logic             wr_setup;
  logic             rd_setup;
  logic             cnt_zero;
  logic             auto_ok;
  logic             host_go;
  logic             auto_go;
  logic             armed;
  logic [15:0]      rd_word;

  // field layout of the written word
  function automatic tcc_setup_t unpack_word(input logic [15:0] w);
    unpack_word = '{
      pen_flow_mode:        w[BIT_PEN],
      resolution_select:    w[BIT_RES],
      adc_rate_select:      w[POS_RATE +: 2],
      panel_settle_time:    w[POS_SETL +: 3],
      precharge_interval:   w[POS_PREC +: 3],
      touch_sense_interval: w[POS_SENS +: 3],
      wait_touch_detect:    w[BIT_WTD],
      long_sample_mode:     w[BIT_LSM]
    };
  endfunction

  // pen input from the panel comparator is asynchronous
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pen_m <= 1'b0;
      pen   <= 1'b0;
    end else begin
      pen_m <= PEN_TOUCH;
      pen   <= pen_m;
    end
  end

  tcc_osc_tick u_tick (
    .clk      (CLOCK),
    .rst_n    (RST_N),
    .rate     (setup.adc_rate_select),
    .osc_tick (osc_tick),
    .adc_tick (adc_tick)
  );

  assign wr_setup = REG_REQ.wr && (REG_REQ.addr == ADDR_SETUP0);
  assign rd_setup = REG_REQ.rd && (REG_REQ.addr == ADDR_SETUP0);
  assign busy     = (state != ST_IDLE);
  assign cnt_zero = (cnt == '0);

  // live pen and idle state on read
  assign rd_word = {pen, ~busy, setup.resolution_select,
                    setup.adc_rate_select, setup.panel_settle_time,
                    setup.precharge_interval, setup.touch_sense_interval,
                    setup.wait_touch_detect, setup.long_sample_mode};

  // device scans only for function codes 0 and 1
  assign auto_ok = setup.pen_flow_mode && armed &&
                   (func == FN_XYZ || func == FN_XY);
  assign auto_go = auto_ok && pen && !stop_req;
  assign host_go = !setup.pen_flow_mode && CTL1.start && !CTL1.stop;

  // setup word and function code
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      setup <= unpack_word(SETUP_RST_WR);
      func  <= 4'h0;
    end else begin
      if (wr_setup) begin
        setup <= unpack_word(REG_REQ.wdata);
      end else if (CTL1.start) begin
        setup.resolution_select <= CTL1.res;
      end
      if (CTL1.start)
        func <= CTL1.func;
    end
  end

  // stop request lives one cycle, then self-clears
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N)
      stop_req <= 1'b0;
    else
      stop_req <= (wr_setup && REG_REQ.wdata[BIT_BUSY]) || CTL1.stop;
  end

  // abort disarms auto scans, else a held pen restarts one
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N)
      armed <= 1'b0;
    else if (CTL1.start && !CTL1.stop)
      armed <= 1'b1;
    else if (stop_req)
      armed <= 1'b0;
  end

  // counters reloaded per step, decremented on oscillator ticks
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    if (osc_tick && !cnt_zero)
      next_cnt = cnt - DLY_W'(1);
    case (state)
      ST_IDLE: begin
        if (host_go || auto_go) begin
          next_state = ST_PREC;
          next_cnt = us_to_osc(PREC_US[setup.precharge_interval]);
        end
      end
      ST_PREC: begin
        if (cnt_zero) begin
          next_state = ST_SETL;
          next_cnt = us_to_osc(SETL_US[setup.panel_settle_time]);
        end
      end
      ST_SETL: begin
        if (cnt_zero) begin
          next_state = ST_SAMP;
          next_cnt = setup.long_sample_mode ? DLY_W'(LONG_OSC) : '0;
        end
      end
      ST_SAMP: begin
        if (cnt_zero)
          next_state = ST_CONV;
      end
      ST_CONV: begin
        if (CONV_DONE) begin
          next_state = ST_SENS;
          next_cnt = us_to_osc(SENS_US[setup.touch_sense_interval]);
        end
      end
      ST_SENS: begin
        if (cnt_zero)
          next_state = (auto_ok && pen) ? ST_PREC : ST_IDLE;
        if (cnt_zero && auto_ok && pen)
          next_cnt = us_to_osc(PREC_US[setup.precharge_interval]);
      end
      default: next_state = ST_IDLE;
    endcase
    if (stop_req) begin
      next_state = ST_IDLE;
      next_cnt   = '0;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // registered outputs
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA               <= SETUP_RST_RD;
      REG_RVALID              <= 1'b0;
      ADC_POWER               <= 1'b0;
      ADC_SAMPLE              <= 1'b0;
      ADC_START               <= 1'b0;
      ADC_RES12               <= 1'b0;
      ADC_CLK_EN              <= 1'b0;
      PANEL_DRIVE             <= 1'b0;
      PANEL_PRECHARGE         <= 1'b0;
      SCAN_ABORTED            <= 1'b0;
      TOUCH_OR_DATA_READY_PIN <= 1'b0;
    end else begin
      REG_RVALID <= rd_setup;
      REG_RDATA  <= rd_word;
      // converter powered only during a scan
      ADC_POWER  <= (next_state != ST_IDLE);
      ADC_SAMPLE <= (next_state == ST_SAMP);
      ADC_START  <= (state == ST_SAMP) && (next_state == ST_CONV);
      ADC_RES12  <= setup.resolution_select;
      ADC_CLK_EN <= adc_tick && (next_state == ST_CONV);
      PANEL_DRIVE     <= (next_state == ST_SETL) ||
                         (next_state == ST_SAMP) ||
                         (next_state == ST_CONV);
      PANEL_PRECHARGE <= (next_state == ST_PREC);
      SCAN_ABORTED    <= stop_req && busy;
      // background detect, high when idle in pen mode 0 with no touch
      TOUCH_OR_DATA_READY_PIN <= !setup.pen_flow_mode &&
                                 setup.wait_touch_detect && !busy && !pen;
    end
  end

  // assertions
  a_stop_self_clear:
    assert property (@(posedge CLOCK) disable iff (!RST_N)
      stop_req && !CTL1.stop && !wr_setup |=> !stop_req)
    else $error("stop request did not self clear");
  a_abort_idles:
    assert property (@(posedge CLOCK) disable iff (!RST_N)
      stop_req |=> state == ST_IDLE && !ADC_POWER)
    else $error("abort did not idle the converter");
  a_busy_read:
    assert property (@(posedge CLOCK) disable iff (!RST_N)
      rd_setup |=> REG_RDATA[BIT_BUSY] == !$past(busy))
    else $error("busy bit read wrong");
  a_pen_read:
    assert property (@(posedge CLOCK) disable iff (!RST_N)
      rd_setup |=> REG_RDATA[BIT_PEN] == $past(pen))
    else $error("pen bit read wrong");
  a_res_write:
    assert property (@(posedge CLOCK) disable iff (!RST_N)
      wr_setup |=> ##1 ADC_RES12 == $past(REG_REQ.wdata[BIT_RES], 2))
    else $error("resolution not applied");
  a_res_ctl_byte:
    assert property (@(posedge CLOCK) disable iff (!RST_N)
      CTL1.start && !wr_setup |=> setup.resolution_select == $past(CTL1.res))
    else $error("control byte resolution lost");
  a_auto_gate:
    assert property (@(posedge CLOCK) disable iff (!RST_N)
      state == ST_IDLE && !auto_ok && !host_go |=> state == ST_IDLE)
    else $error("scan started without permission");
  a_long_sample:
    assert property (@(posedge CLOCK) disable iff (!RST_N)
      state == ST_SETL && cnt_zero && setup.long_sample_mode && !stop_req
      |=> cnt == DLY_W'(LONG_OSC))
    else $error("long sample not loaded");
  a_pin_no_touch:
    assert property (@(posedge CLOCK) disable iff (!RST_N)
      TOUCH_OR_DATA_READY_PIN |-> !$past(pen) && !$past(busy))
    else $error("pin high while touched or busy");
  a_prec_order:
    assert property (@(posedge CLOCK) disable iff (!RST_N)
      state == ST_IDLE && next_state == ST_PREC |=> PANEL_PRECHARGE)
    else $error("precharge not entered");
  a_abort_disarm:
    assert property (@(posedge CLOCK) disable iff (!RST_N)
      stop_req && !CTL1.start |=> !armed)
    else $error("abort left device scans armed");

  c_host_scan: cover property (@(posedge CLOCK) host_go ##1 busy);
  c_auto_scan: cover property (@(posedge CLOCK) auto_go ##1 busy);
  c_abort:     cover property (@(posedge CLOCK) busy && stop_req);
  c_pin_high:  cover property (@(posedge CLOCK) TOUCH_OR_DATA_READY_PIN);
endmodule

/* File: hw/tcc_pkg.sv */
// package: setup word layout, register address and timing constants
package tcc_pkg;

  localparam logic [3:0]  ADDR_SETUP0   = 4'hC;
  localparam logic [15:0] SETUP_RST_WR  = 16'h0000;
  localparam logic [15:0] SETUP_RST_RD  = 16'h4000;

  localparam int BIT_PEN   = 15;
  localparam int BIT_BUSY  = 14;
  localparam int BIT_RES   = 13;
  localparam int POS_RATE  = 11;
  localparam int POS_SETL  = 8;
  localparam int POS_PREC  = 5;
  localparam int POS_SENS  = 2;
  localparam int BIT_WTD   = 1;
  localparam int BIT_LSM   = 0;

  localparam int CLK_MHZ   = 100;
  localparam int OSC_MHZ   = 4;
  localparam int OSC_DIV   = CLK_MHZ / OSC_MHZ;
  localparam int LONG_NS   = 500;
  localparam int LONG_OSC  = 2;

  // delay tables in microseconds of oscillator time
  localparam int SETL_US [8] = '{0, 100, 500, 1000, 5000, 10000, 50000,
                                 100000};
  localparam int PREC_US [8] = '{20, 84, 276, 340, 1044, 1108, 1300, 1364};
  localparam int SENS_US [8] = '{32, 96, 544, 608, 2080, 2144, 2592, 2656};
  localparam int DLY_W = 19;

  localparam logic [3:0] FN_XYZ = 4'h0;
  localparam logic [3:0] FN_XY  = 4'h1;

  typedef enum {ST_IDLE, ST_PREC, ST_SENS, ST_SETL, ST_SAMP, ST_CONV}
    tcc_state_t;

  typedef struct packed {
    logic       pen_flow_mode;
    logic       resolution_select;
    logic [1:0] adc_rate_select;
    logic [2:0] panel_settle_time;
    logic [2:0] precharge_interval;
    logic [2:0] touch_sense_interval;
    logic       wait_touch_detect;
    logic       long_sample_mode;
  } tcc_setup_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } tcc_reg_req_t;

  typedef struct packed {
    logic       start;
    logic [3:0] func;
    logic       res;
    logic       stop;
  } tcc_ctl1_t;

  function automatic logic [DLY_W-1:0] us_to_osc(input int us);
    us_to_osc = DLY_W'(us * OSC_MHZ);
  endfunction

endpackage

/* File: hw/tcc_osc_tick.sv */
// oscillator tick and converter clock divider
`timescale 1ns/1ps
module tcc_osc_tick
  import tcc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] rate,
  output logic            osc_tick,
  output logic            adc_tick
);
  logic [4:0] pre;
  logic [1:0] div;
  logic       pre_end;
  logic       div_end;

  assign pre_end = (pre == 5'(OSC_DIV - 1));
  // divide by 1, 2 or 4
  assign div_end = (rate == 2'h0) ? 1'b1 :
                   (rate == 2'h1) ? div[0] : (div == 2'h3);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre      <= 5'h00;
      div      <= 2'h0;
      osc_tick <= 1'b0;
      adc_tick <= 1'b0;
    end else begin
      pre      <= pre_end ? 5'h00 : pre + 5'h01;
      osc_tick <= pre_end;
      adc_tick <= pre_end & div_end;
      if (pre_end)
        div <= div_end ? 2'h0 : div + 2'h1;
    end
  end
endmodule

/* File: tb/tcc_host_model.sv */
// host and converter stand-in facing the setup block
`timescale 1ns/1ps
module tcc_host_model
  import tcc_pkg::*;
(
  // clock
  input  wire logic          CLOCK,
  // register answer and converter start
  input  wire logic [15:0]   REG_RDATA,
  input  wire logic          REG_RVALID,
  input  wire logic          ADC_START,
  // requests and conversion done
  output tcc_reg_req_t       REG_REQ,
  output tcc_ctl1_t          CTL1,
  output logic               CONV_DONE
);
  import tcc_pkg::*;
  int conv_wait = 300;
  initial begin
    REG_REQ = '0;
    CTL1 = '0;
    CONV_DONE = 1'b0;
  end
  // one whole word per access; released fields show junk
  task automatic reg_op(input logic w, input logic [3:0] a,
                        input logic [15:0] d, output logic [15:0] q);
    REG_REQ <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge CLOCK);
    REG_REQ <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1;
    q = (REG_RVALID === 1'b1) ? REG_RDATA : 'x;
    @(posedge CLOCK);
  endtask
  // scans started only with function codes the host chose
  task automatic ctl(input logic s, input logic [3:0] f, input logic r,
                     input logic p);
    CTL1 <= '{start: s, func: f, res: r, stop: p};
    @(posedge CLOCK);
    CTL1 <= '0;
    @(posedge CLOCK);
  endtask
  // converter finishes a fixed while after each start
  always @(posedge CLOCK) begin
    if (ADC_START === 1'b1) begin
      repeat (conv_wait) @(posedge CLOCK);
      CONV_DONE <= 1'b1;
      @(posedge CLOCK);
      CONV_DONE <= 1'b0;
    end
  end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the setup word block
`timescale 1ns/1ps
module testbench;
  import tcc_pkg::*;
  logic         clock = 1'b0;
  logic         rst_n = 1'b0;
  logic         pen_touch = 1'b0;
  tcc_reg_req_t reg_req;
  tcc_ctl1_t    ctl1;
  logic         conv_done, rvalid, pwr, samp, start, res12, clk_en;
  logic         drive, prech, abt, pin;
  logic [15:0]  rdata, v;
  int           err_count = 0, checked = 0;
  int           n_pre, n_samp, n_clk, n_pow, n_abt, n_drv, n_st;
  always #5 clock = ~clock;
  tcc_setup_ctrl dut (.CLOCK(clock), .RST_N(rst_n), .REG_REQ(reg_req),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .CTL1(ctl1),
    .PEN_TOUCH(pen_touch), .CONV_DONE(conv_done), .ADC_POWER(pwr),
    .ADC_SAMPLE(samp), .ADC_START(start), .ADC_RES12(res12),
    .ADC_CLK_EN(clk_en), .PANEL_DRIVE(drive), .PANEL_PRECHARGE(prech),
    .SCAN_ABORTED(abt), .TOUCH_OR_DATA_READY_PIN(pin));
  tcc_host_model host (.CLOCK(clock), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .ADC_START(start), .REG_REQ(reg_req),
    .CTL1(ctl1), .CONV_DONE(conv_done));
  // phase lengths measured in clocks
  always @(posedge clock) begin
    n_pre += int'(prech === 1'b1);
    n_samp += int'(samp === 1'b1);
    n_clk += int'(clk_en === 1'b1);
    n_pow += int'(pwr === 1'b1);
    n_abt += int'(abt === 1'b1);
    n_drv += int'(drive === 1'b1);
    n_st += int'(start === 1'b1);
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_rng(input int g, input int lo, input int hi);
    checked++;
    if (g < lo || g > hi) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    host.reg_op(1'b1, a, d, v);
  endtask
  task automatic rd();
    host.reg_op(1'b0, ADDR_SETUP0, 16'h0000, v);
  endtask
  task automatic zero();
    {n_pre, n_samp, n_clk, n_pow, n_abt, n_drv, n_st} = '0;
  endtask
  task automatic t_fields();
    rd();
    chk(v, SETUP_RST_RD);
    // undivided rate avoided while 12-bit is chosen
    wr(ADDR_SETUP0, 16'h3BFE);
    rd();
    chk(v, 16'h7BFE);
    wr(4'hD, 16'h0000);
    rd();
    chk(v, 16'h7BFE);
    wr(ADDR_SETUP0, 16'h0002);
    repeat (2) @(posedge clock);
    chk({15'h0, pin}, 16'h0001);
    // touch pulls the pin low and sets the pen bit on read
    pen_touch <= 1'b1;
    repeat (5) @(posedge clock);
    chk({15'h0, pin}, 16'h0000);
    rd();
    chk(v, 16'hC002);
    pen_touch <= 1'b0;
    repeat (3) @(posedge clock);
    $display("test fields done");
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 20000 && pwr !== 1'b0; i++) @(posedge clock);
  endtask
  task automatic t_scan();
    int pre_clk = PREC_US[0] * CLK_MHZ;
    int smp_clk = LONG_OSC * OSC_DIV;
    // long sample with a slower rate, as for a weak supply
    wr(ADDR_SETUP0, 16'h0801);
    zero();
    host.ctl(1'b1, 4'h3, 1'b1, 1'b0);
    rd();
    chk(v & 16'h6000, 16'h2000);
    chk({15'h0, res12}, 16'h0001);
    wait_idle();
    chk_rng(n_pre, pre_clk - 25, pre_clk + 25);
    chk_rng(n_samp, smp_clk - 25, smp_clk + 25);
    chk_rng(n_clk, 5, 7);
    chk_rng(n_st, 1, 1);
    chk_rng(n_drv, 320, 360);
    chk_rng(n_pow, 5400, 5750);
    $display("test scan done");
  endtask
  task automatic t_abort();
    wr(ADDR_SETUP0, 16'h1000);
    zero();
    host.ctl(1'b1, 4'h3, 1'b0, 1'b0);
    repeat (20) @(posedge clock);
    wr(ADDR_SETUP0, 16'h5000);
    rd();
    chk({15'h0, pwr}, 16'h0000);
    chk_rng(n_abt, 1, 1);
    chk(v, 16'h5000);
    $display("test abort done");
  endtask
  task automatic t_rates();
    int set_clk = SETL_US[1] * CLK_MHZ;
    // slowest rate, with a settle delay before sampling
    wr(ADDR_SETUP0, 16'h1100);
    zero();
    host.ctl(1'b1, 4'h3, 1'b0, 1'b0);
    wait_idle();
    chk_rng(n_clk, 2, 4);
    chk_rng(n_drv, set_clk + 270, set_clk + 340);
    // undivided rate only with 10-bit resolution
    wr(ADDR_SETUP0, 16'h0000);
    zero();
    host.ctl(1'b1, 4'h3, 1'b0, 1'b0);
    wait_idle();
    chk_rng(n_clk, 11, 13);
    $display("test rates done");
  endtask
  task automatic t_auto();
    wr(ADDR_SETUP0, 16'h8000);
    // function code 3 left over must keep the pen from scanning
    pen_touch <= 1'b1;
    repeat (10) @(posedge clock);
    chk({15'h0, pwr}, 16'h0000);
    host.ctl(1'b1, FN_XYZ, 1'b0, 1'b0);
    for (int i = 0; i < 60 && pwr !== 1'b1; i++) @(posedge clock);
    chk({15'h0, pwr}, 16'h0001);
    // abort with the pen still down: no restart
    host.ctl(1'b0, FN_XYZ, 1'b0, 1'b1);
    repeat (5) @(posedge clock);
    chk({15'h0, pwr}, 16'h0000);
    pen_touch <= 1'b0;
    repeat (3) @(posedge clock);
    $display("test auto done");
  endtask
  task automatic report_and_stop();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_fields();
    t_scan();
    t_abort();
    t_rates();
    t_auto();
    report_and_stop();
  end
  // whole run needs about 27000 clocks
  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end
endmodule
